// ===== common/hold_judge_pkg.sv
// Shared constants, types and register map for the dual hold judge
package hold_judge_pkg;

  // Register word addresses (byte offsets, 32-bit words)
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_START_LVL = 8'h08;
  localparam logic [7:0] ADDR_UPPER_A = 8'h0c;
  localparam logic [7:0] ADDR_LOWER_A = 8'h10;
  localparam logic [7:0] ADDR_UPPER_B = 8'h14;
  localparam logic [7:0] ADDR_LOWER_B = 8'h18;
  localparam logic [7:0] ADDR_HELD_A = 8'h1c;
  localparam logic [7:0] ADDR_HELD_B = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_PINS = 8'h28;

  // Mode code limits
  localparam logic [4:0] MODE_MAX = 5'h1a;
  localparam logic [4:0] MODE_SINGLE_MAX = 5'h09;
  localparam logic [4:0] MODE_RESET = 5'h00;

  // Limit range and reset values
  localparam int LIMIT_MAX = 99999;
  localparam int LIMIT_MIN = -99999;
  localparam int UPPER_A_RESET = 6000;
  localparam int UPPER_B_RESET = 8000;
  localparam int LOWER_A_RESET = 4000;
  localparam int LOWER_B_RESET = 2000;
  localparam int START_LVL_RESET = 0;

  // Configuration register bit positions
  localparam int CFG_DOUBLE_EN = 0;
  localparam int CFG_EXT_ONLY = 1;
  localparam int CFG_FALL_EDGE = 2;
  localparam int CFG_AUTO_RESET = 3;
  localparam int CFG_CMP_HOLD_A = 4;
  localparam int CFG_CMP_HOLD_B = 5;
  localparam int CFG_WIDTH = 6;

  // Synchroniser depth for pins
  localparam int SYNC_STAGES = 3;

  // Hold function codes
  typedef enum logic [3:0] {
    FN_OFF = 4'h0,
    FN_SAMPLE = 4'h1,
    FN_PEAK = 4'h2,
    FN_VALLEY = 4'h3,
    FN_P2P = 4'h4,
    FN_AVERAGE = 4'h5,
    FN_INFLECT = 4'h6,
    FN_REL_MAX = 4'h7,
    FN_REL_MIN = 4'h8,
    FN_REL_DIFF = 4'h9
  } func_e;

  // Sequence states, Gray along idle -> track -> hold
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TRACK = 2'b01,
    ST_HOLD = 2'b11
  } seq_e;

  typedef struct packed {
    logic cmp_hold_b;
    logic cmp_hold_a;
    logic auto_reset;
    logic fall_edge;
    logic ext_only;
    logic double_en;
  } cfg_s;

  // Filtered control pins from the controller
  typedef struct packed {
    logic [1:0] calibration_select;
    logic plot_trigger_input;
    logic [3:0] work_select;
    logic zero_offset;
    logic release_in;
    logic gate;
  } pins_s;

  localparam int PIN_COUNT = 10;

endpackage

// ===== verilog/hold_unit.sv
// One hold function engine: tracks, accumulates and confirms a held value
`timescale 1ns/10ps
`default_nettype none
module hold_unit
  import hold_judge_pkg::*;
#(
  parameter int VW = 24,
  parameter int CW = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire func_e fn,
  input wire logic clear,
  input wire logic tracking,
  input wire logic meas_valid,
  input wire logic signed [VW-1:0] value,
  input wire logic capture,
  input wire logic armed,
  input wire logic window_end,
  output logic signed [VW-1:0] result,
  output logic done
);
  logic signed [VW-1:0] hi, lo, next_hi, next_lo, next_result;
  logic signed [VW+CW-1:0] sum, next_sum;
  logic [CW-1:0] cnt, next_cnt;
  logic started, next_started, next_done, next_seen, seen;
  logic signed [VW+CW-1:0] avg;

  // Divide only at window close; a zero count yields zero
  assign avg = (cnt == '0) ? '0 : sum / $signed({{VW{1'b0}}, cnt});

  // Next-value logic per function
  always_comb begin
    next_hi = hi;
    next_lo = lo;
    next_sum = sum;
    next_cnt = cnt;
    next_started = started;
    next_seen = seen;
    next_result = result;
    next_done = done;
    if (clear) begin
      next_started = 1'b0;
      next_seen = 1'b0;
      next_sum = '0;
      next_cnt = '0;
      next_done = (fn == FN_OFF);
      next_result = '0;
      // With rising-edge sampling, the gate edge that opens tracking is also the sample instant
      if (fn == FN_SAMPLE && capture) begin // R4
        next_result = value;
        next_done = 1'b1;
      end
    end else if (tracking && !done) begin
      if (armed) begin
        next_started = 1'b1;
      end
      case (fn)
        FN_SAMPLE: begin
          if (capture) begin // R4
            next_result = value;
            next_done = 1'b1;
          end
        end
        FN_PEAK, FN_VALLEY, FN_P2P, FN_AVERAGE: begin
          if (meas_valid) begin
            next_hi = (!seen || value > hi) ? value : hi; // R5
            next_lo = (!seen || value < lo) ? value : lo; // R6
            next_sum = sum + (VW+CW)'(value); // R25
            next_cnt = cnt + 1'b1;
            next_seen = 1'b1;
          end
          if (window_end) begin
            next_done = 1'b1;
            case (fn)
              FN_PEAK: next_result = hi;
              FN_VALLEY: next_result = lo;
              FN_P2P: next_result = hi - lo; // R7
              default: next_result = avg[VW-1:0]; // R8
            endcase
          end
        end
        FN_INFLECT, FN_REL_MAX, FN_REL_MIN, FN_REL_DIFF: begin
          // Unless external-only is set, nothing is tracked before the start level has been met
          if (meas_valid && (started || armed)) begin // R9 R10
            next_hi = (!seen || value > hi) ? value : hi;
            next_lo = (!seen || value < lo) ? value : lo;
            next_seen = 1'b1;
            // Turning point: first reversal after the start
            if (seen && fn != FN_REL_DIFF) begin
              if (fn == FN_REL_MIN && value > lo) begin
                next_result = lo;
                next_done = 1'b1;
              end else if (fn != FN_REL_MIN && value < hi) begin
                next_result = hi;
                next_done = 1'b1;
              end
            end
          end
          if (window_end) begin
            next_done = 1'b1;
            case (fn)
              FN_REL_MIN: next_result = lo;
              FN_REL_DIFF: next_result = hi - lo; // R11
              default: next_result = hi;
            endcase
          end
        end
        default: next_done = 1'b1;
      endcase
    end
  end

  // State registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hi <= '0;
      lo <= '0;
      sum <= '0;
      cnt <= '0;
      started <= 1'b0;
      seen <= 1'b0;
      result <= '0;
      done <= 1'b0;
    end else begin
      hi <= next_hi;
      lo <= next_lo;
      sum <= next_sum;
      cnt <= next_cnt;
      started <= next_started;
      seen <= next_seen;
      result <= next_result;
      done <= next_done;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/dual_hold_limit_judge.sv
// Dual hold and limit judgment block with register port and control pins
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Operation
// R1 - Mode code 0..26 picks A/B function pair
// R2 - Both functions run together in one window
// R3 - Double hold enable defaults off, gates B
// R4 - Sample captures value at gate edge
// R5 - Peak keeps largest value in window
// R6 - Valley keeps smallest value in window
// R7 - Peak-to-peak keeps maximum minus minimum
// R8 - Average keeps mean over window
// R9 - Inflection search starts after gate, start level
// R10 - Relative modes start after gate, start level
// R11 - Relative difference is max minus min
// R12 - External-only ignores level; hold until release
// R13 - Sample plus inflection external-only needs no level
// R14 - Double hold keeps values until release
// R15 - Signed upper limits A/B, defaults 6000/8000
// R16 - Signed lower limits A/B, defaults 4000/2000
// R17 - Flags: strictly above upper, below lower
// R18 - Pass only when all four flags off
// R19 - Separate comparison timing for A and B
// R20 - Timing unmet forces that function's flags off
// R21 - Flags, pass, done, run, event are outputs
// R22 - Sample edge rising, or falling with window
// R23 - Auto reset restarts at gate, else release
// R24 - Done when all active confirmed; release clears
// R25 - Average accumulates per update, divides at close
module dual_hold_limit_judge
  import hold_judge_pkg::*;
#(
  parameter int VW = 24,
  parameter int CW = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic meas_valid,
  input wire logic signed [VW-1:0] meas_data,
  input wire logic [PIN_COUNT-1:0] pins_in,
  output logic upper_flag_first,
  output logic lower_flag_first,
  output logic upper_flag_second,
  output logic lower_flag_second,
  output logic pass,
  output logic capture_done,
  output logic run,
  output logic event_out
);
  // Elaboration checks on widths
  if (VW < 18 || VW > 32) begin : g_vw_check
    $error("VW must be 18 to 32 to hold the limit range");
  end
  if (CW < 2 || CW > 32) begin : g_cw_check
    $error("CW must be 2 to 32");
  end

  localparam logic signed [VW-1:0] LIM_HI = VW'(LIMIT_MAX);
  localparam logic signed [VW-1:0] LIM_LO = VW'(LIMIT_MIN);

  // Three-stage synchronisers; level accepted once stages 2 and 3 agree
  logic [PIN_COUNT-1:0] sync1, sync2, sync3, pin_lvl, next_pin_lvl;
  pins_s pins;
  assign pins = pins_s'(pin_lvl);

  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      next_pin_lvl[i] = (sync2[i] == sync3[i]) ? sync3[i] : pin_lvl[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin_lvl <= '0;
    end else begin
      sync1 <= pins_in;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_lvl <= next_pin_lvl; // R21
    end
  end

  // Edges of the filtered gate and release levels
  logic gate_d, rel_d, zero_d;
  logic gate_rise, gate_fall, rel_rise, zero_rise;
  assign gate_rise = pins.gate && !gate_d;
  assign gate_fall = !pins.gate && gate_d;
  assign rel_rise = pins.release_in && !rel_d;
  assign zero_rise = pins.zero_offset && !zero_d;

  // Register file
  logic [4:0] mode, next_mode;
  cfg_s cfg, next_cfg;
  logic signed [VW-1:0] start_lvl, next_start_lvl;
  logic signed [VW-1:0] upper_a, upper_b, lower_a, lower_b;
  logic signed [VW-1:0] next_upper_a, next_upper_b;
  logic signed [VW-1:0] next_lower_a, next_lower_b;
  logic signed [VW-1:0] wr_val, wr_clamped;
  logic [31:0] next_rdata;

  assign wr_val = reg_wdata[VW-1:0];
  // Out-of-range limit writes saturate rather than wrap
  assign wr_clamped = (wr_val > LIM_HI) ? LIM_HI :
                      (wr_val < LIM_LO) ? LIM_LO : wr_val;

  // Held values and status gathered here for reads
  logic signed [VW-1:0] held_a, held_b;
  logic done_a, done_b;
  seq_e st, next_st;

  always_comb begin
    next_mode = mode;
    next_cfg = cfg;
    next_start_lvl = start_lvl;
    next_upper_a = upper_a;
    next_upper_b = upper_b;
    next_lower_a = lower_a;
    next_lower_b = lower_b;
    next_rdata = '0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_MODE: begin
          if (reg_wdata <= {27'h0, MODE_MAX}) begin // R1
            next_mode = reg_wdata[4:0];
          end
        end
        ADDR_CFG: next_cfg = cfg_s'(reg_wdata[CFG_WIDTH-1:0]);
        ADDR_START_LVL: next_start_lvl = wr_clamped;
        ADDR_UPPER_A: next_upper_a = wr_clamped; // R15
        ADDR_UPPER_B: next_upper_b = wr_clamped; // R15
        ADDR_LOWER_A: next_lower_a = wr_clamped; // R16
        ADDR_LOWER_B: next_lower_b = wr_clamped; // R16
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_MODE: next_rdata = 32'(mode);
        ADDR_CFG: next_rdata = 32'(cfg);
        ADDR_START_LVL: next_rdata = 32'(start_lvl);
        ADDR_UPPER_A: next_rdata = 32'(upper_a);
        ADDR_UPPER_B: next_rdata = 32'(upper_b);
        ADDR_LOWER_A: next_rdata = 32'(lower_a);
        ADDR_LOWER_B: next_rdata = 32'(lower_b);
        ADDR_HELD_A: next_rdata = 32'(held_a);
        ADDR_HELD_B: next_rdata = 32'(held_b);
        ADDR_STATUS: next_rdata = 32'({st, done_b, done_a, pass,
          lower_flag_second, upper_flag_second, lower_flag_first,
          upper_flag_first, capture_done});
        ADDR_PINS: next_rdata = 32'(pin_lvl);
        default: next_rdata = '0;
      endcase
    end
  end

  // Limits reset to their documented defaults; double hold starts off
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode <= MODE_RESET;
      cfg <= '0; // R3
      start_lvl <= VW'(START_LVL_RESET);
      upper_a <= VW'(UPPER_A_RESET); // R15
      upper_b <= VW'(UPPER_B_RESET); // R15
      lower_a <= VW'(LOWER_A_RESET); // R16
      lower_b <= VW'(LOWER_B_RESET); // R16
      reg_rdata <= '0;
    end else begin
      mode <= next_mode;
      cfg <= next_cfg;
      start_lvl <= next_start_lvl;
      upper_a <= next_upper_a;
      upper_b <= next_upper_b;
      lower_a <= next_lower_a;
      lower_b <= next_lower_b;
      reg_rdata <= next_rdata;
    end
  end

  // Mode decode to a function pair; pairs need double hold enabled
  func_e fn_a, fn_b;
  logic has_window;
  always_comb begin
    fn_a = FN_OFF;
    fn_b = FN_OFF;
    case (mode) // R1
      5'h0a: begin fn_a = FN_SAMPLE; fn_b = FN_PEAK; end
      5'h0b: begin fn_a = FN_SAMPLE; fn_b = FN_VALLEY; end
      5'h0c: begin fn_a = FN_SAMPLE; fn_b = FN_P2P; end
      5'h0d: begin fn_a = FN_SAMPLE; fn_b = FN_AVERAGE; end
      5'h0e: begin fn_a = FN_SAMPLE; fn_b = FN_INFLECT; end
      5'h0f: begin fn_a = FN_SAMPLE; fn_b = FN_REL_MAX; end
      5'h10: begin fn_a = FN_SAMPLE; fn_b = FN_REL_MIN; end
      5'h11: begin fn_a = FN_SAMPLE; fn_b = FN_REL_DIFF; end
      5'h12: begin fn_a = FN_PEAK; fn_b = FN_VALLEY; end
      5'h13: begin fn_a = FN_PEAK; fn_b = FN_P2P; end
      5'h14: begin fn_a = FN_VALLEY; fn_b = FN_P2P; end
      5'h15: begin fn_a = FN_AVERAGE; fn_b = FN_PEAK; end
      5'h16: begin fn_a = FN_AVERAGE; fn_b = FN_VALLEY; end
      5'h17: begin fn_a = FN_AVERAGE; fn_b = FN_P2P; end
      5'h18: begin fn_a = FN_REL_MAX; fn_b = FN_REL_MIN; end
      5'h19: begin fn_a = FN_REL_MAX; fn_b = FN_REL_DIFF; end
      5'h1a: begin fn_a = FN_REL_MIN; fn_b = FN_REL_DIFF; end
      default: begin
        if (mode <= MODE_SINGLE_MAX) begin
          fn_a = func_e'(mode[3:0]);
        end
      end
    endcase
    // Without double hold a pair code is not allowed to run
    if (!cfg.double_en && mode > MODE_SINGLE_MAX) begin // R3
      fn_a = FN_OFF;
      fn_b = FN_OFF;
    end
    has_window = fn_a != FN_SAMPLE && fn_a != FN_OFF ||
                 (fn_b != FN_OFF);
  end

  // Sample instant: falling edge only where a window exists
  logic capture;
  assign capture = (cfg.fall_edge && has_window) ? gate_fall
                                                 : gate_rise; // R22

  // Start level gate; external-only skips the threshold entirely
  logic armed;
  assign armed = pins.gate &&
                 (cfg.ext_only || meas_data >= start_lvl); // R12 R13

  // Zero offset: value measured when the zero pin rises becomes zero
  logic signed [VW-1:0] zero_ofs, next_zero_ofs, value;
  assign value = meas_data - zero_ofs;
  assign next_zero_ofs = (zero_rise && meas_valid) ? meas_data : zero_ofs;

  // Hold sequence
  logic clear, tracking, all_done;
  assign all_done = done_a && done_b;
  assign tracking = (st == ST_TRACK);

  always_comb begin
    next_st = st;
    clear = 1'b0;
    case (st)
      ST_IDLE: begin
        if (gate_rise && fn_a != FN_OFF) begin
          next_st = ST_TRACK;
          clear = 1'b1;
        end
      end
      ST_TRACK: begin
        if (all_done) begin // R24
          next_st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Values stay until release unless auto reset restarts
        if (cfg.auto_reset && gate_rise) begin // R23
          next_st = ST_TRACK;
          clear = 1'b1;
        end
      end
      default: next_st = ST_IDLE;
    endcase
    if (rel_rise) begin // R14 R23 R24
      next_st = ST_IDLE;
      clear = 1'b1;
    end
  end

  // Two engines run side by side on the same window
  hold_unit #(.VW(VW), .CW(CW)) u_hold_a ( // R2
    .mclk(mclk),
    .sys_rst(sys_rst),
    .fn(fn_a),
    .clear(clear),
    .tracking(tracking),
    .meas_valid(meas_valid),
    .value(value),
    .capture(capture),
    .armed(armed),
    .window_end(gate_fall),
    .result(held_a),
    .done(done_a)
  );

  hold_unit #(.VW(VW), .CW(CW)) u_hold_b ( // R2
    .mclk(mclk),
    .sys_rst(sys_rst),
    .fn(fn_b),
    .clear(clear),
    .tracking(tracking),
    .meas_valid(meas_valid),
    .value(value),
    .capture(capture),
    .armed(armed),
    .window_end(gate_fall),
    .result(held_b),
    .done(done_b)
  );

  // Judgment; timing "hold" compares only confirmed values
  logic cmp_ok_a, cmp_ok_b, act_b;
  logic next_up_a, next_lo_a, next_up_b, next_lo_b;
  assign act_b = (fn_b != FN_OFF);
  assign cmp_ok_a = (fn_a != FN_OFF) &&
                    (!cfg.cmp_hold_a || done_a); // R19
  assign cmp_ok_b = act_b && (!cfg.cmp_hold_b || done_b); // R19
  assign next_up_a = cmp_ok_a && (held_a > upper_a); // R17 R20
  assign next_lo_a = cmp_ok_a && (held_a < lower_a); // R17 R20
  assign next_up_b = cmp_ok_b && (held_b > upper_b); // R17 R20
  assign next_lo_b = cmp_ok_b && (held_b < lower_b); // R17 R20

  // Output and edge registers; every output leaves from a flop
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= ST_IDLE;
      gate_d <= 1'b0;
      rel_d <= 1'b0;
      zero_d <= 1'b0;
      zero_ofs <= '0;
      upper_flag_first <= 1'b0;
      lower_flag_first <= 1'b0;
      upper_flag_second <= 1'b0;
      lower_flag_second <= 1'b0;
      pass <= 1'b0;
      capture_done <= 1'b0;
      run <= 1'b0;
      event_out <= 1'b0;
    end else begin
      st <= next_st;
      gate_d <= pins.gate;
      rel_d <= pins.release_in;
      zero_d <= pins.zero_offset;
      zero_ofs <= next_zero_ofs;
      upper_flag_first <= next_up_a; // R21
      lower_flag_first <= next_lo_a;
      upper_flag_second <= next_up_b;
      lower_flag_second <= next_lo_b;
      pass <= !(next_up_a || next_lo_a ||
                next_up_b || next_lo_b); // R18
      capture_done <= (next_st == ST_HOLD); // R24
      run <= 1'b1;
      // One-cycle pulse when a hold is confirmed
      event_out <= (st == ST_TRACK) && (next_st == ST_HOLD);
    end
  end
endmodule
`default_nettype wire

// ===== tb/dual_hold_limit_judge_sva.sv
// Port-level assertion checker for the dual hold judge
`timescale 1ns/10ps
`default_nettype none
module dual_hold_limit_judge_sva
  import hold_judge_pkg::*;
#(
  parameter int VW = 24
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic meas_valid,
  input wire logic signed [VW-1:0] meas_data,
  input wire logic [PIN_COUNT-1:0] pins_in,
  input wire logic upper_flag_first,
  input wire logic lower_flag_first,
  input wire logic upper_flag_second,
  input wire logic lower_flag_second,
  input wire logic pass,
  input wire logic capture_done,
  input wire logic run,
  input wire logic event_out
);
  logic [4:0] mode_q;
  logic [4:0] next_mode_q;
  logic flag_any;

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Shadow of the mode code; out-of-range writes are dropped
  always_comb begin
    next_mode_q = mode_q;
    if (reg_wr && reg_addr == ADDR_MODE && reg_wdata <= {27'h0, MODE_MAX}) begin
      next_mode_q = reg_wdata[4:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_q <= MODE_RESET;
    end else begin
      mode_q <= next_mode_q;
    end
  end

  assign flag_any = upper_flag_first | lower_flag_first |
                    upper_flag_second | lower_flag_second;

  // Two quiet cycles; pass is registered in the same cycle as the flags
  sequence flags_quiet;
    (!flag_any && !sys_rst) [*2];
  endsequence

  // Release long enough for the pin filter to act
  sequence release_held;
    $rose(pins_in[1]) ##0 pins_in[1] [*8];
  endsequence

  // Held result left alone: no release, no register writes
  sequence hold_untouched;
    (capture_done && !pins_in[1] && !reg_wr) [*6];
  endsequence

  AST_PASS_ON: assert property (flags_quiet |-> pass)
    else $error("pass low while all flags low");
  AST_PASS_OFF: assert property (flag_any [*2] |-> !pass)
    else $error("pass high while a flag is high");
  AST_RUN: assert property (!sys_rst |=> run)
    else $error("run low out of reset");
  AST_EVENT_PULSE: assert property (event_out |=> !event_out)
    else $error("event longer than one cycle");
  AST_EVENT_DONE: assert property ($rose(capture_done) |-> event_out)
    else $error("done rose without event");
  AST_RELEASE_CLEAR: assert property (release_held |=> !capture_done)
    else $error("done still high after release");
  AST_READ_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  AST_B_FLAGS_OFF: assert property ((mode_q <= MODE_SINGLE_MAX) [*3] |->
    !upper_flag_second && !lower_flag_second)
    else $error("second flags on in a single mode");
  AST_HOLD_STEADY: assert property (hold_untouched |=>
    capture_done && $stable({upper_flag_first, lower_flag_first,
    upper_flag_second, lower_flag_second}))
    else $error("held result changed before release");
endmodule
`default_nettype wire

// ===== tb/controller_model.sv
// Controller model driving gate, release and the spare control pins
`timescale 1ns/10ps
`default_nettype none
module controller_model (
  input wire logic mclk,
  output logic [9:0] pins_in
);
  initial pins_in = 10'h000;

  // Gate opens and closes the section window
  task automatic set_gate(input logic g);
    @(posedge mclk);
    pins_in[0] <= g;
  endtask

  // Release kept long enough for the input filter to see it
  task automatic pulse_release();
    @(posedge mclk);
    pins_in[1] <= 1'b1;
    repeat (10) @(posedge mclk);
    pins_in[1] <= 1'b0;
  endtask

  // Work, plot and calibration pins; zero offset stays low
  task automatic set_misc(input logic [6:0] m);
    @(posedge mclk);
    pins_in[9:3] <= m;
  endtask
endmodule
`default_nettype wire

// ===== tb/test_dual_hold_limit_judge.sv
// Self-checking bench for the dual hold judge
`timescale 1ns/10ps
`default_nettype none
bind dual_hold_limit_judge dual_hold_limit_judge_sva #(.VW(VW)) chk_u (
  .mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .meas_valid, .meas_data, .pins_in, .upper_flag_first, .lower_flag_first,
  .upper_flag_second, .lower_flag_second, .pass, .capture_done, .run,
  .event_out);
module test_dual_hold_limit_judge
  import hold_judge_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic meas_valid = 1'b0;
  logic signed [23:0] meas_data = 24'h0;
  logic rd_seen = 1'b0;
  wire [31:0] reg_rdata;
  wire [9:0] pins_in;
  wire upa, loa, upb, lob, pass, capture_done, run, event_out;
  int num_errors = 0;
  int check_count = 0;
  logic [31:0] exp_q[$];
  int md[10] = '{2, 3, 4, 5, 1, 13, 18, 23, 7, 9};
  int fa[10] = '{2, 3, 4, 5, 1, 1, 2, 5, 7, 4};
  int fb[10] = '{0, 0, 0, 0, 0, 5, 3, 4, 0, 0};
  logic [7:0] ra[7] = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h00, 8'h04, 8'h3c};
  int rv[7] = '{6000, 4000, 8000, 2000, 0, 0, 0};

  always #4 mclk = ~mclk;

  dual_hold_limit_judge dut_u (.mclk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .meas_valid, .meas_data, .pins_in,
    .upper_flag_first(upa), .lower_flag_first(loa),
    .upper_flag_second(upb), .lower_flag_second(lob), .pass,
    .capture_done, .run, .event_out);
  controller_model cm_u (.mclk, .pins_in);

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input int id);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: output %0d is %b", $time, id, got);
    end
  endtask

  task automatic final_report;
    $display("Checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input int d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= 32'(d);
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Expected word queued now, compared when the data appears
  task automatic reg_read(input logic [7:0] a, input int e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(32'(e));
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_seen) begin
      check_word(reg_rdata, exp_q.pop_front());
    end
    rd_seen <= reg_rd;
  end

  task automatic pulse(input int v);
    @(posedge mclk);
    meas_valid <= 1'b1;
    meas_data <= 24'(v);
    @(posedge mclk);
    meas_valid <= 1'b0;
  endtask

  // Value s stands at the gate edge; random values fill the window
  task automatic window(input int s, output int mx, output int mn,
                        output int av, output int rx);
    int v;
    int sum;
    mx = -200000;
    mn = 200000;
    rx = -1;
    sum = 0;
    pulse(s);
    cm_u.set_gate(1'b1);
    repeat (8) @(posedge mclk);
    for (int i = 0; i < 5; i++) begin
      v = $urandom_range(11999);
      pulse(v);
      sum += v;
      // Relative max settles at the first drop below the running max
      if (i > 0 && rx < 0 && v < mx) rx = mx;
      mx = (v > mx) ? v : mx;
      mn = (v < mn) ? v : mn;
    end
    av = sum / 5;
    if (rx < 0) rx = mx;
    cm_u.set_gate(1'b0);
    repeat (12) @(posedge mclk);
  endtask

  function automatic int fval(input int f, s, mx, mn, av, rx);
    case (f)
      7: return rx;
      1: return s;
      2: return mx;
      3: return mn;
      4: return mx - mn;
      default: return av;
    endcase
  endfunction

  initial begin
    int s, mx, mn, av, rx, ha, hb;
    void'($urandom(32'hf7ea5f3b));
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (ra[i]) reg_read(ra[i], rv[i]);
    reg_write(ADDR_MODE, 27);
    reg_write(ADDR_MODE, 33);
    reg_read(ADDR_MODE, 0);
    reg_write(ADDR_UPPER_A, 200000);
    reg_write(ADDR_LOWER_A, -200000);
    reg_read(ADDR_UPPER_A, LIMIT_MAX);
    reg_read(ADDR_LOWER_A, LIMIT_MIN);
    reg_write(ADDR_UPPER_A, UPPER_A_RESET);
    reg_write(ADDR_LOWER_A, LOWER_A_RESET);
    foreach (md[k]) begin
      cm_u.set_misc(7'($urandom));
      reg_write(ADDR_CFG, int'(md[k] > 9) | int'($urandom & 32'h32));
      reg_write(ADDR_MODE, md[k]);
      s = $urandom_range(11999);
      window(s, mx, mn, av, rx);
      ha = fval(fa[k], s, mx, mn, av, rx);
      hb = (fb[k] != 0) ? fval(fb[k], s, mx, mn, av, rx) : 0;
      reg_read(ADDR_HELD_A, ha);
      if (fb[k] != 0) reg_read(ADDR_HELD_B, hb);
      #1;
      check_bit(capture_done, 1'b1, 0);
      check_bit(upa, ha > 6000, 1);
      check_bit(loa, ha < 4000, 2);
      check_bit(upb, fb[k] != 0 && hb > 8000, 3);
      check_bit(lob, fb[k] != 0 && hb < 2000, 4);
      check_bit(pass, !(ha > 6000 || ha < 4000 || (fb[k] != 0 &&
        (hb > 8000 || hb < 2000))), 5);
      cm_u.pulse_release();
      repeat (4) @(posedge mclk);
      #1;
      check_bit(capture_done, 1'b0, 6);
    end
    repeat (4) @(posedge mclk);
    final_report();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #(8 * 20000);
    num_errors++;
    $display("Error at %0t: timeout", $time);
    final_report();
  end
endmodule
`default_nettype wire
